// [design/eprom_programmer_sequencer.sv]
// Purpose: EPROM programmer sequencer: load, check, blank, program, verify
// Assumes: panel and socket pins are asynchronous; one 20 MHz clock
// Notes:   image buffer is flip-flops; key entry only while idle
// What this block does
// [RULE1] The whole image lives in an internal buffer and every written byte comes from it.
// [RULE2] The sequencer offers blank check, programming and a verify pass.
// [RULE3] The contact and reversal checks run before the blank check starts.
// [RULE4] A reversed device sends the sequencer to idle, lights the reversed lamp and stops all drive to the socket.
// [RULE5] Blank check reads every location and passes only if all bits are 1.
// [RULE6] Blank check stops at the first 0 bit and lights the warning lamp.
// [RULE7] Each address is read first and skipped when it already matches the buffer.
// [RULE8] A programmed location is read back and the address advances only on a match.
// [RULE9] A location that will not program stops the run with a failure.
// [RULE10] Verify compares the target with the buffer and stops at the first mismatch.
// [RULE11] A verify failure lights the fail lamp and shows the failing address and data.
// [RULE12] Copy-load fills the buffer from every location of a master device in the socket.
// [RULE13] Buffer bytes can be entered or corrected from front-panel keys before programming.
// [RULE14] Each pass sweeps from the first to the last address of the chosen size; the verify and copy passes flag done.
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_sequencer
  import eprom_seq_pkg::*;
#(
  parameter int ADDR_W    = ADDR_W_DEF,
  parameter int MAX_TRIES = MAX_TRIES_DEF
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  startProgram,
  input  wire logic                  startCopy,
  input  wire logic                  keyWrite,
  input  wire logic [ADDR_W-1:0]     keyAddr,
  input  wire logic [7:0]            keyData,
  input  wire logic [SIZE_SEL_W-1:0] sizeSel,
  input  wire logic                  contactOk,
  input  wire logic                  reversedIn,
  input  wire logic [7:0]            tgtDataIn,
  output logic      [ADDR_W-1:0]     tgtAddr,
  output logic      [7:0]            tgtDataOut,
  output logic                       tgtDataOe,
  output logic                       tgtReadEn,
  output logic                       tgtProgPulse,
  output logic                       busy,
  output logic                       done,
  output logic                       failLamp,
  output logic                       warnLamp,
  output logic                       reversedLamp,
  output logic      [ADDR_W-1:0]     failAddr,
  output logic      [7:0]            failData
);
  localparam int PIN_W = PIN_CTRL_W + ADDR_W + 8 + SIZE_SEL_W;

  tgt_req_if #(.AW(ADDR_W)) tbus ();

  // pin synchroniser; panel buses are quasi-static while keys settle
  logic [PIN_W-1:0]      pinS1_r;
  logic [PIN_W-1:0]      pinS2_r;
  logic [PIN_CTRL_W-1:0] ctrlPrev_r;
  logic [PIN_CTRL_W-1:0] ctrlS;
  logic [ADDR_W-1:0]     keyAddrS;
  logic [7:0]            keyDataS;
  logic [SIZE_SEL_W-1:0] sizeSelS;
  logic                  progEdge;
  logic                  copyEdge;
  logic                  keyEdge;
  logic                  revS;

  always_ff @(posedge sys_clk) begin
    pinS1_r <= {sizeSel, keyData, keyAddr, reversedIn, contactOk, keyWrite, startCopy, startProgram};
    pinS2_r <= pinS1_r;
  end

  assign ctrlS    = pinS2_r[PIN_CTRL_W-1:0];
  assign keyAddrS = pinS2_r[PIN_CTRL_W +: ADDR_W];
  assign keyDataS = pinS2_r[PIN_CTRL_W + ADDR_W +: 8];
  assign sizeSelS = pinS2_r[PIN_CTRL_W + ADDR_W + 8 +: SIZE_SEL_W];
  assign revS     = ctrlS[PIN_REVERSED];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrlPrev_r <= '0;
    end else begin
      ctrlPrev_r <= ctrlS;
    end
  end

  assign progEdge = ctrlS[PIN_PROG] & ~ctrlPrev_r[PIN_PROG];
  assign copyEdge = ctrlS[PIN_COPY] & ~ctrlPrev_r[PIN_COPY];
  assign keyEdge  = ctrlS[PIN_KEY] & ~ctrlPrev_r[PIN_KEY];

  // sequencer state
  seq_state_t        st_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        tries_r;
  logic              pend_r;
  logic              req_r;
  logic              wr_r;
  logic              abort_r;
  logic [ADDR_W-1:0] lastAddr;
  logic              isLast;
  logic [7:0]        bufByte;
  logic              memWe;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0]        memData;
  logic [7:0]        mem [2**ADDR_W];

  // last address of the chosen device size, clipped to the buffer
  always_comb begin
    lastAddr = ADDR_W'((SIZE_BASE_WORDS << sizeSelS) - 1);
    if ((SIZE_BASE_WORDS << sizeSelS) > (2**ADDR_W)) begin
      lastAddr = '1;
    end
  end

  assign isLast  = (addr_r == lastAddr); // see [RULE14]
  assign bufByte = mem[addr_r];

  assign tbus.req   = req_r;
  assign tbus.wr    = wr_r;
  assign tbus.abort = abort_r;
  assign tbus.addr  = addr_r;
  assign tbus.wdata = bufByte; // see [RULE1]

  // buffer writes: copy-load from the socket or panel keys while idle
  always_comb begin
    memWe   = 1'b0;
    memAddr = addr_r;
    memData = tbus.rdata;
    if (st_r == S_COPY && tbus.ack) begin
      memWe = 1'b1; // see [RULE12]
    end else if (st_r == S_IDLE && keyEdge) begin
      memWe   = 1'b1; // see [RULE13]
      memAddr = keyAddrS;
      memData = keyDataS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[memAddr] <= memData; // see [RULE1]
    end
  end

  // reversal forces every socket drive off at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= revS; // see [RULE4]
    end
  end

  always_ff @(posedge sys_clk) begin
    req_r <= 1'b0;
    if (!rst_n) begin
      st_r         <= S_IDLE;
      addr_r       <= '0;
      tries_r      <= '0;
      pend_r       <= 1'b0;
      wr_r         <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      failLamp     <= 1'b0;
      warnLamp     <= 1'b0;
      reversedLamp <= 1'b0;
      failAddr     <= '0;
      failData     <= '0;
    end else if (revS) begin
      st_r         <= S_IDLE; // see [RULE4]
      pend_r       <= 1'b0;
      busy         <= 1'b0;
      reversedLamp <= 1'b1;
    end else begin
      // issue one access per step; the answer comes back as ack
      if (st_r inside {S_BLANK, S_PRE, S_PULSE, S_POST, S_VERIFY, S_COPY} && !pend_r) begin
        req_r  <= 1'b1;
        wr_r   <= (st_r == S_PULSE);
        pend_r <= 1'b1;
      end
      if (tbus.ack) begin
        pend_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          if (progEdge || copyEdge) begin
            busy         <= 1'b1;
            done         <= 1'b0;
            failLamp     <= 1'b0;
            warnLamp     <= 1'b0;
            reversedLamp <= 1'b0;
            addr_r       <= '0;
            st_r         <= progEdge ? S_CHECK : S_COPY;
          end
        end
        S_CHECK: begin
          if (ctrlS[PIN_CONTACT]) begin
            st_r <= S_BLANK; // see [RULE3]
          end else begin
            failLamp <= 1'b1;
            busy     <= 1'b0;
            st_r     <= S_IDLE;
          end
        end
        S_BLANK: begin
          if (tbus.ack) begin
            if (tbus.rdata != ERASED_BYTE) begin
              warnLamp <= 1'b1; // see [RULE6]
              failLamp <= 1'b1;
              failAddr <= addr_r;
              failData <= tbus.rdata;
              busy     <= 1'b0;
              st_r     <= S_IDLE;
            end else if (isLast) begin
              addr_r <= '0; // see [RULE5]
              st_r   <= S_PRE; // see [RULE2]
            end else begin
              addr_r <= addr_r + 1'b1;
            end
          end
        end
        S_PRE: begin
          if (tbus.ack) begin
            tries_r <= '0;
            if (tbus.rdata != bufByte) begin
              st_r <= S_PULSE;
            end else if (isLast) begin
              addr_r <= '0; // see [RULE7]
              st_r   <= S_VERIFY;
            end else begin
              addr_r <= addr_r + 1'b1;
            end
          end
        end
        S_PULSE: begin
          if (tbus.ack) begin
            tries_r <= tries_r + 1'b1;
            st_r    <= S_POST;
          end
        end
        S_POST: begin
          if (tbus.ack) begin
            if (tbus.rdata == bufByte) begin
              st_r <= S_PRE; // see [RULE8]
              if (isLast) begin
                addr_r <= '0;
                st_r   <= S_VERIFY;
              end else begin
                addr_r <= addr_r + 1'b1;
              end
            end else if (tries_r >= 8'(MAX_TRIES)) begin
              failLamp <= 1'b1; // see [RULE9]
              failAddr <= addr_r;
              failData <= tbus.rdata;
              busy     <= 1'b0;
              st_r     <= S_IDLE;
            end else begin
              st_r <= S_PULSE;
            end
          end
        end
        S_VERIFY: begin
          if (tbus.ack) begin
            if (tbus.rdata != bufByte) begin
              failLamp <= 1'b1; // see [RULE10]
              failAddr <= addr_r; // see [RULE11]
              failData <= tbus.rdata;
              busy     <= 1'b0;
              st_r     <= S_IDLE;
            end else if (isLast) begin
              st_r <= S_DONE;
            end else begin
              addr_r <= addr_r + 1'b1;
            end
          end
        end
        S_COPY: begin
          if (tbus.ack) begin
            if (isLast) begin
              st_r <= S_DONE;
            end else begin
              addr_r <= addr_r + 1'b1;
            end
          end
        end
        S_DONE: begin
          done <= 1'b1; // see [RULE14]
          busy <= 1'b0;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  target_access #(.ADDR_W(ADDR_W)) u_access (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .bus          (tbus),
    .tgtDataIn    (tgtDataIn),
    .tgtAddr      (tgtAddr),
    .tgtDataOut   (tgtDataOut),
    .tgtDataOe    (tgtDataOe),
    .tgtReadEn    (tgtReadEn),
    .tgtProgPulse (tgtProgPulse)
  );
endmodule // eprom_programmer_sequencer
`default_nettype wire

// [design/eprom_seq_pkg.sv]
// Purpose: shared constants for the EPROM programmer sequencer
// Assumes: 20 MHz sys_clk
// Notes:   timing figures are in ns; cycle counts derive from them
package eprom_seq_pkg;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int ADDR_W_DEF      = 14;
  localparam int DATA_W          = 8;
  // smallest selectable device, doubled by each step of the size select
  localparam int SIZE_BASE_WORDS = 2048;
  localparam int SIZE_SEL_W      = 2;
  // target read access time, a least time: rounded up
  localparam int READ_ACCESS_NS  = 450;
  // two extra cycles cover the data synchroniser
  localparam int READ_CYC        = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  // one program pulse on the target
  localparam int PROG_PULSE_NS   = 50000;
  localparam int PROG_PULSE_CYC  = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_TRIES_DEF   = 15;
  localparam int TIMER_W         = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // panel pin vector layout: control bits in the low bits, below the key and size buses
  localparam int PIN_PROG     = 0;
  localparam int PIN_COPY     = 1;
  localparam int PIN_KEY      = 2;
  localparam int PIN_CONTACT  = 3;
  localparam int PIN_REVERSED = 4;
  localparam int PIN_CTRL_W   = 5;

  typedef enum {
    S_IDLE, S_CHECK, S_BLANK, S_PRE, S_PULSE, S_POST, S_VERIFY, S_COPY, S_DONE
  } seq_state_t;

  typedef enum {A_IDLE, A_READ, A_PROG} acc_state_t;
endpackage

// [design/tgt_req_if.sv]
// Purpose: request path between sequencer and target socket driver
// Assumes: single clock domain
// Notes:   req and ack are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface tgt_req_if #(parameter int AW = 14);
  logic          req;
  logic          wr;
  logic          abort;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          ack;
  logic [7:0]    rdata;
  modport seq  (output req, wr, abort, addr, wdata, input ack, rdata);
  modport port (input req, wr, abort, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// [design/target_access.sv]
// Purpose: drives the socket pins for one read or one program pulse
// Assumes: tgtDataIn is asynchronous to sys_clk
// Notes:   abort drops every drive at once and discards the request
`timescale 1ns/1ps
`default_nettype none
module target_access
  import eprom_seq_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  tgt_req_if.port                bus,
  input  wire logic [7:0]        tgtDataIn,
  output logic      [ADDR_W-1:0] tgtAddr,
  output logic      [7:0]        tgtDataOut,
  output logic                   tgtDataOe,
  output logic                   tgtReadEn,
  output logic                   tgtProgPulse
);
  acc_state_t         st_r;
  logic [TIMER_W-1:0] cnt_r;
  logic [7:0]         dSync1_r;
  logic [7:0]         dSync2_r;
  logic               ack_r;
  logic [7:0]         rdata_r;

  assign bus.ack   = ack_r;
  assign bus.rdata = rdata_r;

  always_ff @(posedge sys_clk) begin
    dSync1_r <= tgtDataIn;
    dSync2_r <= dSync1_r;
  end

  always_ff @(posedge sys_clk) begin
    ack_r <= 1'b0;
    if (!rst_n || bus.abort) begin
      st_r         <= A_IDLE;
      cnt_r        <= '0;
      tgtAddr      <= '0;
      tgtDataOut   <= '0;
      tgtDataOe    <= 1'b0;
      tgtReadEn    <= 1'b0;
      tgtProgPulse <= 1'b0;
      rdata_r      <= '0;
    end else begin
      case (st_r)
        A_IDLE: begin
          if (bus.req) begin
            tgtAddr <= bus.addr;
            if (bus.wr) begin
              // data only ever comes from the image buffer
              tgtDataOut   <= bus.wdata; // see [RULE1]
              tgtDataOe    <= 1'b1;
              tgtProgPulse <= 1'b1;
              cnt_r        <= TIMER_W'(PROG_PULSE_CYC - 1);
              st_r         <= A_PROG;
            end else begin
              tgtReadEn <= 1'b1;
              cnt_r     <= TIMER_W'(READ_CYC - 1);
              st_r      <= A_READ;
            end
          end
        end
        A_READ: begin
          if (cnt_r == '0) begin
            rdata_r   <= dSync2_r;
            tgtReadEn <= 1'b0;
            ack_r     <= 1'b1;
            st_r      <= A_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        A_PROG: begin
          if (cnt_r == '0) begin
            tgtProgPulse <= 1'b0;
            tgtDataOe    <= 1'b0;
            ack_r        <= 1'b1;
            st_r         <= A_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= A_IDLE;
      endcase
    end
  end
endmodule // target_access
`default_nettype wire

// [bench/eprom_seq_monitor.sv]
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the sequencer top
`timescale 1ns/1ps
`default_nettype none
module eprom_seq_monitor
  import eprom_seq_pkg::*;
#(
  parameter int ADDR_W    = ADDR_W_DEF,
  parameter int MAX_TRIES = MAX_TRIES_DEF
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              startProgram,
  input wire logic              reversedIn,
  input wire logic [ADDR_W-1:0] tgtAddr,
  input wire logic              tgtDataOe,
  input wire logic              tgtReadEn,
  input wire logic              tgtProgPulse,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              failLamp,
  input wire logic              warnLamp
);
  logic [10:0]       pulseLen;
  logic [ADDR_W-1:0] pulseAddr;
  logic [7:0]        tries;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk) begin
    pulseLen <= (rst_n && tgtProgPulse) ? pulseLen + 11'd1 : 11'd0;
  end
  // pulses spent on one address
  always_ff @(posedge sys_clk) begin
    if (!rst_n || $rose(busy)) begin
      tries <= 8'd0;
      pulseAddr <= '0;
    end else if ($rose(tgtProgPulse)) begin
      pulseAddr <= tgtAddr;
      tries <= (tgtAddr == pulseAddr) ? tries + 8'd1 : 8'd1;
    end
  end
  sequence readHigh;
    tgtReadEn[*8] ##1 tgtReadEn[*3];
  endsequence
  sequence readBack;
    ##[1:6] (tgtReadEn && tgtAddr == pulseAddr);
  endsequence
  a_read_len: assert property (disable iff (!rst_n || reversedIn) $rose(tgtReadEn) |-> readHigh ##1 !tgtReadEn)
    else $error("read access length wrong");
  a_pulse_len: assert property (disable iff (!rst_n || reversedIn) $fell(tgtProgPulse) |-> pulseLen == PROG_PULSE_CYC)
    else $error("program pulse length wrong");
  a_pulse_data: assert property (tgtProgPulse |-> tgtDataOe && !tgtReadEn)
    else $error("pulse without data drive");
  a_read_back: assert property (disable iff (!rst_n || reversedIn) $fell(tgtProgPulse) |-> readBack)
    else $error("no read-back after pulse");
  a_idle_quiet: assert property ((!busy)[*3] |-> !(tgtReadEn || tgtProgPulse || tgtDataOe))
    else $error("socket driven while idle");
  a_rev_stop: assert property (reversedIn[*6] |-> !busy && !tgtProgPulse && !tgtDataOe && !tgtReadEn)
    else $error("reversal did not stop run");
  a_start_busy: assert property ($rose(startProgram) && !busy && !reversedIn |-> ##[2:5] busy)
    else $error("start not taken");
  a_done_end: assert property ($rose(done) |-> $fell(busy) && !failLamp)
    else $error("done without end of run");
  a_warn_fail: assert property ($rose(warnLamp) |-> failLamp && !done)
    else $error("warn lamp without fail");
  a_fail_stop: assert property ($rose(failLamp) |-> ##[0:2] (!busy && !done))
    else $error("run went on after failure");
  a_try_limit: assert property ($rose(tgtProgPulse) |=> tries <= MAX_TRIES)
    else $error("too many pulses on one address");
endmodule // eprom_seq_monitor
bind eprom_programmer_sequencer eprom_seq_monitor #(.ADDR_W(ADDR_W), .MAX_TRIES(MAX_TRIES)) u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .startProgram(startProgram), .reversedIn(reversedIn),
  .tgtAddr(tgtAddr), .tgtDataOe(tgtDataOe), .tgtReadEn(tgtReadEn), .tgtProgPulse(tgtProgPulse),
  .busy(busy), .done(done), .failLamp(failLamp), .warnLamp(warnLamp));
`default_nettype wire

// [bench/eprom_socket_model.sv]
// Purpose: behavioural erasable device in the socket
// Assumes: a pulse only clears bits
// Notes: stuck and weak faults switched on by the bench
`timescale 1ns/1ps
`default_nettype none
module eprom_socket_model #(
  parameter int AW = 4
) (
  input  wire logic          sys_clk,
  input  wire logic [AW-1:0] tgtAddr,
  input  wire logic [7:0]    tgtDataOut,
  input  wire logic          tgtDataOe,
  input  wire logic          tgtReadEn,
  input  wire logic          tgtProgPulse,
  input  wire logic          stuckEn,
  input  wire logic          weakEn,
  input  wire logic [AW-1:0] faultAddr,
  output logic      [7:0]    tgtDataIn
);
  logic [7:0] mem [2**AW];
  logic [7:0] last = 8'h00;
  logic       readQ = 1'b0;
  int         hits = 0;
  task automatic erase();
    foreach (mem[i]) mem[i] = 8'hFF;
    // fresh device: weak-cell read count starts over
    hits = 0;
  endtask
  initial erase();
  always @(posedge sys_clk) begin
    if (tgtProgPulse && tgtDataOe && !(stuckEn && tgtAddr == faultAddr)) begin
      mem[tgtAddr] <= mem[tgtAddr] & tgtDataOut;
    end
    // weak cell holds only until its second read after a pulse
    if (tgtProgPulse && tgtAddr == faultAddr) begin
      hits <= 0;
    end else if (tgtReadEn && !readQ && tgtAddr == faultAddr) begin
      hits <= hits + 1;
    end
    readQ <= tgtReadEn;
    if (tgtReadEn) begin
      last <= tgtDataIn;
    end
  end
  // released bus shows the inverse of the last byte
  always_comb begin
    tgtDataIn = ~last;
    if (tgtReadEn) begin
      tgtDataIn = mem[tgtAddr] ^ ((weakEn && tgtAddr == faultAddr && hits >= 2) ? 8'h01 : 8'h00);
    end
  end
endmodule // eprom_socket_model
`default_nettype wire

// [bench/eprom_programmer_sequencer_test.sv]
// Purpose: self-checking bench for the sequencer
// Assumes: 20 MHz clock, 16-word sweeps
// Notes: results queued by the driver, checked when busy drops
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_sequencer_test;
  import eprom_seq_pkg::*;
  localparam int AW = 4;
  localparam int MT = 3;
  localparam int N  = 2**AW;
  typedef struct packed {logic [15:0] v; logic [15:0] m;} note_t;
  logic          sys_clk = 0;
  logic          rst_n = 0;
  logic          startProgram = 0;
  logic          startCopy = 0;
  logic          keyWrite = 0;
  logic [AW-1:0] keyAddr = 4'h0;
  logic [7:0]    keyData = 8'h00;
  logic          contactOk = 1;
  logic          reversedIn = 0;
  logic          stuckEn = 0;
  logic          weakEn = 0;
  logic [AW-1:0] faultAddr = 4'h3;
  logic [7:0]    tgtDataIn, tgtDataOut, failData;
  logic [AW-1:0] tgtAddr, failAddr;
  logic          tgtDataOe, tgtReadEn, tgtProgPulse, busy, done, failLamp, warnLamp, reversedLamp;
  logic [7:0]    img [N];
  note_t         notes [$];
  note_t         n;
  int            fails = 0;
  int            checks = 0;
  int            pulses = 0;
  int            p0;
  logic          pulseQ = 0;
  logic          busyQ = 0;

  always #25 sys_clk = ~sys_clk;

  eprom_programmer_sequencer #(.ADDR_W(AW), .MAX_TRIES(MT)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .startProgram(startProgram), .startCopy(startCopy),
    .keyWrite(keyWrite), .keyAddr(keyAddr), .keyData(keyData), .sizeSel(2'b00),
    .contactOk(contactOk), .reversedIn(reversedIn), .tgtDataIn(tgtDataIn), .tgtAddr(tgtAddr),
    .tgtDataOut(tgtDataOut), .tgtDataOe(tgtDataOe), .tgtReadEn(tgtReadEn),
    .tgtProgPulse(tgtProgPulse), .busy(busy), .done(done), .failLamp(failLamp),
    .warnLamp(warnLamp), .reversedLamp(reversedLamp), .failAddr(failAddr), .failData(failData));

  eprom_socket_model #(.AW(AW)) u_eprom (
    .sys_clk(sys_clk), .tgtAddr(tgtAddr), .tgtDataOut(tgtDataOut), .tgtDataOe(tgtDataOe),
    .tgtReadEn(tgtReadEn), .tgtProgPulse(tgtProgPulse), .stuckEn(stuckEn), .weakEn(weakEn),
    .faultAddr(faultAddr), .tgtDataIn(tgtDataIn));

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic key(input logic [AW-1:0] a, input logic [7:0] d);
    keyAddr <= a;
    keyData <= d;
    tick(4);
    keyWrite <= 1'b1;
    tick(4);
    keyWrite <= 1'b0;
    tick(1);
  endtask
  task automatic run(input string name, input logic cp, input logic [15:0] v, input logic [15:0] m);
    int k;
    k = 0;
    notes.push_back('{v, m});
    if (cp) startCopy <= 1'b1;
    else startProgram <= 1'b1;
    tick(6);
    startCopy <= 1'b0;
    startProgram <= 1'b0;
    while (busy === 1'b1 && k < 30000) begin
      tick(1);
      k++;
    end
    if (k == 30000) fails++;
    tick(3);
    $display("test %s ended", name);
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // result = done, fail, warn, reversed, address, data
  always @(negedge sys_clk) begin
    if (busyQ && !busy) begin
      if (notes.size() == 0) fails++;
      else begin
        n = notes.pop_front();
        check({done, failLamp, warnLamp, reversedLamp, failAddr, failData} & n.m, n.v & n.m);
      end
    end
    busyQ = busy;
  end
  always @(posedge sys_clk) begin
    if (tgtProgPulse && !pulseQ) pulses++;
    pulseQ = tgtProgPulse;
  end

  initial begin
    int nz;
    void'($urandom(74));
    tick(5);
    rst_n <= 1'b1;
    tick(3);
    nz = 0;
    for (int i = 0; i < N; i++) begin
      img[i] = ($urandom % 2) ? 8'hFF : 8'($urandom);
      if (i == 0) img[i] = img[i] & 8'h7F;
      if (i == 3) img[i] = 8'h3C;
      if (img[i] != 8'hFF) nz++;
      key(4'(i), img[i]);
    end
    run("program", 0, 16'h8000, 16'hF000);
    check(16'(pulses), 16'(nz));
    for (int i = 0; i < N; i++) check({8'h00, u_eprom.mem[i]}, {8'h00, img[i]});
    p0 = pulses;
    run("blank", 0, {4'h6, 4'h0, img[0]}, 16'hFFFF);
    check(16'(pulses), 16'(p0));
    u_eprom.erase();
    stuckEn <= 1'b1;
    p0 = pulses;
    nz = 0;
    for (int i = 0; i < 3; i++) if (img[i] != 8'hFF) nz++;
    run("stuck", 0, {4'h4, 4'h3, 8'hFF}, 16'hFFFF);
    check(16'(pulses - p0), 16'(nz + MT));
    u_eprom.erase();
    stuckEn <= 1'b0;
    weakEn <= 1'b1;
    run("weak", 0, {4'h4, 4'h3, 8'h3D}, 16'hFFFF);
    weakEn <= 1'b0;
    for (int i = 0; i < N; i++) begin
      img[i] = 8'($urandom);
      u_eprom.mem[i] = img[i];
    end
    run("copy", 1, 16'h8000, 16'hF000);
    img[7] = 8'hA5;
    key(4'h7, img[7]);
    u_eprom.erase();
    run("copied image", 0, 16'h8000, 16'hF000);
    for (int i = 0; i < N; i++) check({8'h00, u_eprom.mem[i]}, {8'h00, img[i]});
    contactOk <= 1'b0;
    p0 = pulses;
    run("contact", 0, 16'h4000, 16'hF000);
    check(16'(pulses), 16'(p0));
    contactOk <= 1'b1;
    u_eprom.erase();
    fork
      run("reversed", 0, 16'h1000, 16'hB000);
      begin
        tick(300);
        reversedIn <= 1'b1;
      end
    join
    check({13'h0000, tgtReadEn, tgtProgPulse, tgtDataOe}, 16'h0000);
    reversedIn <= 1'b0;
    tick(5);
    summarize();
  end
  initial begin
    tick(90000);
    fails++;
    summarize();
  end
endmodule // eprom_programmer_sequencer_test
`default_nettype wire
